// File: hdl/qcs_pkg.sv
/*
  Constants, field layout and carrier types for the quick clock switch
  control block.
  Assumes one 125 MHz system clock and an 8-bit special-function bus.
*/
package qcs_pkg;

  localparam logic [7:0] CTRL_ADDR        = 8'h80;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam int         METER_SEL_BIT    = 7;
  localparam int         FAST_WAKE_BIT    = 6;
  localparam int         FAST_SLEEP_BIT   = 5;
  localparam int         METER_GATE_BIT   = 4;
  localparam int         DISP_GATE_BIT    = 3;
  localparam int         SLEEP_HIGH_BIT   = 2;
  localparam int         SLEEP_LOW_BIT    = 1;
  localparam int         CORE_SEL_BIT     = 0;
  localparam logic [1:0] SLEEP_DEEP_CODE  = 2'h2;

  // Frequency the PLL is forced to by fast-wake
  localparam int         QUICK_PLL_HZ     = 3276800;

  localparam int         CLK_PERIOD_NS    = 8;
  // Longest time from crystal switchover to core clock stop
  localparam int         STOP_LIMIT_NS    = 30000;
  localparam int         STOP_LIMIT_CYC   = STOP_LIMIT_NS / CLK_PERIOD_NS;
  // Glitch-free settle before the core clock is gated off
  localparam int         STOP_SETTLE_NS   = 64;
  localparam int         STOP_SETTLE_CYC  =
    (STOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         CNT_W            = 12;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } qcs_sfr_req_type;

  typedef struct packed {
    logic core_clk_sel;
    logic core_clk_run;
    logic aux_clk_run;
    logic meter_clk_sel;
    logic meter_clk_run;
    logic display_clk_run;
    logic pll_enable;
    logic pll_fixed_freq;
    logic pll_cfg_block;
    logic light_sleep_state;
    logic deep_sleep_state;
    logic temp_state;
  } qcs_clk_ctrl_type;

  typedef enum logic [1:0] {
    QCS_RUN,
    QCS_SWITCH,
    QCS_STOPPED
  } qcs_state_type;

endpackage

// File: hdl/qcs_sync.sv
/*
  Two-stage level synchroniser for a vector of independent bits.
  Assumes every bit is a slow level or a pulse wider than two clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module qcs_sync
  import qcs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Only the second stage may read the first
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// File: hdl/qcs_ctrl.sv
/*
  Clock switchover control register and sequencer: core and metering clock
  selection and gating, display clock gating with core and metering both on the PLL, quick wake and quick sleep.
  Assumes an 8-bit SFR bus on mclk, analog PLL control outside, and
  reset and wake events arriving as asynchronous pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module qcs_ctrl
  import qcs_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Special-function register bus
  input  wire qcs_sfr_req_type  sfr_req,
  output logic [7:0]            sfr_rdata,
  // System status, asynchronous
  input  wire logic             power_good_flag,
  input  wire logic             reset_event,
  input  wire logic             wake_event,
  // Same-domain inputs from other registers
  input  wire logic             wake_without_reset_sel,
  input  wire logic             analog_pll_enable,
  // Clock control outputs
  output qcs_clk_ctrl_type      clk_ctrl,
  output logic                  energy_const_accum
);

  // Synchronised pins
  logic [2:0]    pin_sync;
  logic          reset_seen;
  logic          wake_seen;

  // Register fields and sequencer state
  logic          meter_clock_source_sel;
  logic          fast_wake_bit;
  logic          fast_sleep_bit;
  logic          meter_clock_gate;
  logic          display_clock_gate;
  logic [1:0]    sleep_select;
  logic          core_clock_source_sel;
  logic          quick_pll_on;
  logic          temp_state;
  logic          deep_pending;
  logic          light_sleep;
  logic          deep_sleep;
  qcs_state_type state;
  logic [CNT_W-1:0] stop_cnt;

  logic          next_meter_clock_source_sel;
  logic          next_fast_wake_bit;
  logic          next_fast_sleep_bit;
  logic          next_meter_clock_gate;
  logic          next_display_clock_gate;
  logic [1:0]    next_sleep_select;
  logic          next_core_clock_source_sel;
  logic          next_quick_pll_on;
  logic          next_temp_state;
  logic          next_deep_pending;
  logic          next_light_sleep;
  logic          next_deep_sleep;
  qcs_state_type next_state;
  logic [CNT_W-1:0] next_stop_cnt;

  qcs_sync #(
    .WIDTH    (3)
  ) qcs_sync_inst (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({power_good_flag, reset_event, wake_event}),
    .sync_out (pin_sync)
  );

  // Decode
  wire       pg           = pin_sync[2];
  wire       reset_hit    = pin_sync[1] & ~reset_seen;
  wire       wake_hit     = pin_sync[0] & ~wake_seen;
  wire       keep_state   = wake_hit & wake_without_reset_sel;
  wire       full_clear   = reset_hit | (wake_hit & ~wake_without_reset_sel);
  wire       addr_hit     = sfr_req.addr == CTRL_ADDR;
  // Writes are taken in QCS_RUN only, so none land during the sleep switch or once stopped
  wire       wr           = addr_hit & sfr_req.wr & (state == QCS_RUN);
  wire [7:0] wd           = sfr_req.wdata;
  wire       quick_locked = fast_wake_bit & ~fast_sleep_bit;
  wire       fw_write_ok  = wr & ~fast_sleep_bit;
  wire       fs_set       = wr & wd[FAST_SLEEP_BIT];
  wire       fw_set       = fw_write_ok & wd[FAST_WAKE_BIT] & ~fs_set;
  wire       core_sel_ok  = wr & ~quick_locked & ~fs_set & ~fw_set;
  wire       quick_sleep  = fs_set & ~pg;
  wire       sleep_req    = wr & ~fs_set & ~pg & ~core_clock_source_sel
                            & ~wd[CORE_SEL_BIT]
                            & (wd[SLEEP_HIGH_BIT] | wd[SLEEP_LOW_BIT]);
  wire       sleep_deep   = wd[SLEEP_HIGH_BIT:SLEEP_LOW_BIT]
                            == SLEEP_DEEP_CODE;
  wire [7:0] read_value   = {meter_clock_source_sel, fast_wake_bit,
                             fast_sleep_bit, meter_clock_gate,
                             display_clock_gate, sleep_select,
                             core_clock_source_sel};

  always_comb
  begin
    next_meter_clock_source_sel = meter_clock_source_sel;
    next_fast_wake_bit          = fast_wake_bit;
    next_fast_sleep_bit         = fast_sleep_bit;
    next_meter_clock_gate       = meter_clock_gate;
    next_display_clock_gate     = display_clock_gate;
    next_sleep_select           = sleep_select;
    next_core_clock_source_sel  = core_clock_source_sel;
    next_quick_pll_on           = quick_pll_on;
    next_temp_state             = temp_state;
    next_deep_pending           = deep_pending;
    next_light_sleep            = light_sleep;
    next_deep_sleep             = deep_sleep;
    next_state                  = state;
    next_stop_cnt               = stop_cnt;
    if (full_clear)
    begin
      next_meter_clock_source_sel = CTRL_RESET[METER_SEL_BIT];
      next_fast_wake_bit          = CTRL_RESET[FAST_WAKE_BIT];
      next_fast_sleep_bit         = CTRL_RESET[FAST_SLEEP_BIT];
      next_meter_clock_gate       = CTRL_RESET[METER_GATE_BIT];
      next_display_clock_gate     = CTRL_RESET[DISP_GATE_BIT];
      next_sleep_select           = CTRL_RESET[SLEEP_HIGH_BIT:SLEEP_LOW_BIT];
      next_core_clock_source_sel  = CTRL_RESET[CORE_SEL_BIT];
      next_quick_pll_on           = 1'b0;
      next_temp_state             = 1'b1;
      next_deep_pending           = 1'b0;
      next_light_sleep            = 1'b0;
      next_deep_sleep             = 1'b0;
      next_state                  = QCS_RUN;
      next_stop_cnt               = '0;
    end
    else if (keep_state)
    begin
      next_fast_wake_bit  = 1'b0;
      next_fast_sleep_bit = 1'b0;
      next_sleep_select   = 2'b00;
      next_temp_state     = ~core_clock_source_sel;
      next_light_sleep    = 1'b0;
      next_deep_sleep     = 1'b0;
      next_state          = QCS_RUN;
      next_stop_cnt       = '0;
    end
    else
    begin
      if (wr)
      begin
        next_meter_clock_source_sel = wd[METER_SEL_BIT];
        next_meter_clock_gate       = wd[METER_GATE_BIT];
        next_display_clock_gate     = wd[DISP_GATE_BIT];
        next_sleep_select           = wd[SLEEP_HIGH_BIT:SLEEP_LOW_BIT];
        next_fast_sleep_bit         = wd[FAST_SLEEP_BIT];
      end
      if (fw_write_ok)
        next_fast_wake_bit = wd[FAST_WAKE_BIT];
      if (core_sel_ok)
        next_core_clock_source_sel = wd[CORE_SEL_BIT];
      if (fw_set)
      begin
        next_quick_pll_on = 1'b1;
        next_core_clock_source_sel = 1'b1;
      end
      if (fs_set)
      begin
        next_core_clock_source_sel = 1'b0;
        next_quick_pll_on          = 1'b0;
      end
      if (quick_sleep | sleep_req)
      begin
        next_deep_pending = sleep_req & sleep_deep;
        next_state        = QCS_SWITCH;
        next_stop_cnt     = CNT_W'(STOP_SETTLE_CYC - 1);
      end
      case (state)
        QCS_RUN:
        begin
        end
        QCS_SWITCH:
        begin
          if (stop_cnt == '0)
          begin
            next_state       = QCS_STOPPED;
            next_light_sleep = ~deep_pending;
            next_deep_sleep  = deep_pending;
          end
          else
            next_stop_cnt = stop_cnt - CNT_W'(1);
        end
        QCS_STOPPED:
        begin
        end
        default:
          next_state = QCS_RUN;
      endcase
      if (next_core_clock_source_sel)
        next_temp_state = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meter_clock_source_sel <= CTRL_RESET[METER_SEL_BIT];
      fast_wake_bit          <= CTRL_RESET[FAST_WAKE_BIT];
      fast_sleep_bit         <= CTRL_RESET[FAST_SLEEP_BIT];
      meter_clock_gate       <= CTRL_RESET[METER_GATE_BIT];
      display_clock_gate     <= CTRL_RESET[DISP_GATE_BIT];
      sleep_select           <= CTRL_RESET[SLEEP_HIGH_BIT:SLEEP_LOW_BIT];
      core_clock_source_sel  <= CTRL_RESET[CORE_SEL_BIT];
      quick_pll_on           <= 1'b0;
      temp_state             <= 1'b1;
      deep_pending           <= 1'b0;
      light_sleep            <= 1'b0;
      deep_sleep             <= 1'b0;
      state                  <= QCS_RUN;
      stop_cnt               <= '0;
    end
    else
    begin
      meter_clock_source_sel <= next_meter_clock_source_sel;
      fast_wake_bit          <= next_fast_wake_bit;
      fast_sleep_bit         <= next_fast_sleep_bit;
      meter_clock_gate       <= next_meter_clock_gate;
      display_clock_gate     <= next_display_clock_gate;
      sleep_select           <= next_sleep_select;
      core_clock_source_sel  <= next_core_clock_source_sel;
      quick_pll_on           <= next_quick_pll_on;
      temp_state             <= next_temp_state;
      deep_pending           <= next_deep_pending;
      light_sleep            <= next_light_sleep;
      deep_sleep             <= next_deep_sleep;
      state                  <= next_state;
      stop_cnt               <= next_stop_cnt;
    end
  end

  // Edge memory for event pulses
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reset_seen <= 1'b0;
      wake_seen  <= 1'b0;
    end
    else
    begin
      reset_seen <= pin_sync[1];
      wake_seen  <= pin_sync[0];
    end
  end

  // Clock control outputs follow the next values so a switch shows on the same edge that takes the write; sfr_rdata reads the current register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      clk_ctrl           <= '0;
      clk_ctrl.core_clk_run    <= 1'b1;
      clk_ctrl.aux_clk_run     <= 1'b1;
      clk_ctrl.meter_clk_run   <= 1'b1;
      clk_ctrl.display_clk_run <= 1'b1;
      clk_ctrl.temp_state      <= 1'b1;
      energy_const_accum <= 1'b1;
      sfr_rdata          <= 8'h00;
    end
    else
    begin
      clk_ctrl.core_clk_sel      <= next_core_clock_source_sel;
      clk_ctrl.core_clk_run      <= next_state != QCS_STOPPED;
      clk_ctrl.aux_clk_run       <= next_state != QCS_STOPPED;
      clk_ctrl.meter_clk_sel     <= next_meter_clock_source_sel;
      clk_ctrl.meter_clk_run     <= ~next_meter_clock_gate;
      clk_ctrl.display_clk_run   <= ~(next_display_clock_gate
                                      & next_core_clock_source_sel
                                      & next_meter_clock_source_sel);
      clk_ctrl.pll_enable        <= next_quick_pll_on | analog_pll_enable;
      clk_ctrl.pll_fixed_freq    <= next_quick_pll_on;
      clk_ctrl.pll_cfg_block     <= next_fast_wake_bit & ~next_fast_sleep_bit;
      clk_ctrl.light_sleep_state <= next_light_sleep;
      clk_ctrl.deep_sleep_state  <= next_deep_sleep;
      clk_ctrl.temp_state        <= next_temp_state;
      energy_const_accum         <= next_temp_state;
      sfr_rdata <= (addr_hit & sfr_req.rd) ? read_value : 8'h00;
    end
  end

endmodule
`default_nettype wire

// File: sim/qcs_ctrl_assertions.sv
/*
  Port-level assertions for the quick clock switch control block.
  Assumes one mclk domain with synchronous active-low rst_n.
*/
`timescale 1ns/1ns
`default_nettype none
module qcs_ctrl_checker
  import qcs_pkg::*;
(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst_n,
  // Register bus
  input wire qcs_sfr_req_type  sfr_req,
  input wire logic [7:0]       sfr_rdata,
  // Status, events and clock control
  input wire logic             power_good_flag,
  input wire logic             reset_event,
  input wire logic             wake_event,
  input wire logic             wake_without_reset_sel,
  input wire logic             analog_pll_enable,
  input wire qcs_clk_ctrl_type clk_ctrl,
  input wire logic             energy_const_accum
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic wrote;
  wire  ctrl_wr = sfr_req.wr && sfr_req.addr == CTRL_ADDR;
  wire  ctrl_rd = sfr_req.rd && sfr_req.addr == CTRL_ADDR;
  wire  quick_sleep = ctrl_wr && sfr_req.wdata[6:5] == 2'h1;
  wire  quick_clear = ctrl_wr && sfr_req.wdata[6:5] == 2'h0
                      && sfr_req.wdata[2:1] == 2'h0;

  // Register still clear, so the sequencer is known to be running
  always_ff @(posedge mclk)
    if (!rst_n)
      wrote <= 1'b0;
    else if (ctrl_wr)
      wrote <= 1'b1;

  a_fast_wake_now: assert property (
    !wrote && ctrl_wr && sfr_req.wdata == 8'h40 |=> clk_ctrl.core_clk_sel
    && clk_ctrl.pll_fixed_freq && clk_ctrl.pll_enable && !clk_ctrl.temp_state)
    else $error("fast wake did not switch core to PLL");
  a_quick_sleep_stop: assert property (
    clk_ctrl.pll_cfg_block && quick_sleep && !power_good_flag
    && !$past(power_good_flag, 3) |=> !clk_ctrl.core_clk_sel
    && !clk_ctrl.pll_fixed_freq ##8 !clk_ctrl.core_clk_run
    && clk_ctrl.light_sleep_state)
    else $error("fast sleep did not stop core into light sleep");
  a_pg_no_sleep: assert property (
    clk_ctrl.pll_cfg_block && quick_sleep && power_good_flag
    && $past(power_good_flag, 3) |=> !clk_ctrl.core_clk_sel
    ##1 (clk_ctrl.core_clk_run && !clk_ctrl.light_sleep_state)[*8])
    else $error("fast sleep with power good entered sleep");
  a_unlock_keeps_pll: assert property (
    clk_ctrl.pll_cfg_block && quick_clear
    |=> clk_ctrl.core_clk_sel && !clk_ctrl.pll_cfg_block)
    else $error("unlock moved the core clock source");
  a_lock_fixed_pll: assert property (
    clk_ctrl.pll_cfg_block |-> clk_ctrl.core_clk_sel
    && clk_ctrl.pll_fixed_freq && clk_ctrl.pll_enable)
    else $error("config lock without fixed PLL on core");
  a_display_gate_pll: assert property (
    !clk_ctrl.display_clk_run
    |-> clk_ctrl.core_clk_sel && clk_ctrl.meter_clk_sel)
    else $error("display clock stopped off full PLL");
  a_sleep_core_off: assert property (
    clk_ctrl.light_sleep_state || clk_ctrl.deep_sleep_state
    |-> !clk_ctrl.core_clk_run && !clk_ctrl.core_clk_sel
    && !(clk_ctrl.light_sleep_state && clk_ctrl.deep_sleep_state))
    else $error("sleep state with core clock live");
  a_aux_with_core: assert property (
    clk_ctrl.aux_clk_run == clk_ctrl.core_clk_run)
    else $error("auxiliary clock differs from core clock");
  a_energy_in_temp: assert property (
    energy_const_accum == clk_ctrl.temp_state)
    else $error("constant accumulation differs from temp state");
  a_read_idle_zero: assert property (
    !ctrl_rd |=> sfr_rdata == 8'h00)
    else $error("read data without a register read");
endmodule

bind qcs_ctrl qcs_ctrl_checker qcs_ctrl_checker_inst (
  .mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .power_good_flag(power_good_flag), .reset_event(reset_event),
  .wake_event(wake_event), .wake_without_reset_sel(wake_without_reset_sel),
  .analog_pll_enable(analog_pll_enable), .clk_ctrl(clk_ctrl),
  .energy_const_accum(energy_const_accum));
`default_nettype wire

// File: sim/tb_quick_clock_switch_control.sv
/*
  Self-checking bench for qcs_ctrl: quick wake and sleep, sleep codes,
  gating and events. Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_quick_clock_switch_control
  import qcs_pkg::*;
;
  logic             mclk;
  logic             rst_n;
  qcs_sfr_req_type  sfr_req;
  logic [7:0]       sfr_rdata;
  logic             power_good_flag;
  logic             reset_event;
  logic             wake_event;
  logic             wake_without_reset_sel;
  logic             analog_pll_enable;
  qcs_clk_ctrl_type clk_ctrl;
  logic             energy_const_accum;
  int               miscompares;
  int               total_checks;
  int               cycles;
  logic [7:0]       codes [3];

  qcs_ctrl qcs_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .power_good_flag(power_good_flag),
    .reset_event(reset_event), .wake_event(wake_event),
    .wake_without_reset_sel(wake_without_reset_sel),
    .analog_pll_enable(analog_pll_enable), .clk_ctrl(clk_ctrl),
    .energy_const_accum(energy_const_accum));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic put(input logic [7:0] d);
    @(posedge mclk);
    sfr_req <= '{CTRL_ADDR, 1'b1, 1'b0, d};
    @(posedge mclk);
    sfr_req <= '0;
    #1;
  endtask

  task automatic get(input logic [7:0] exp);
    @(posedge mclk);
    sfr_req <= '{CTRL_ADDR, 1'b0, 1'b1, 8'h00};
    @(posedge mclk);
    sfr_req <= '0;
    #1;
    check(sfr_rdata, exp);
  endtask

  // Events are held three cycles to clear the synchroniser
  task automatic pulse(input logic wake);
    @(posedge mclk);
    wake_event  <= wake;
    reset_event <= !wake;
    repeat (3) @(posedge mclk);
    wake_event  <= 1'b0;
    reset_event <= 1'b0;
    tick(6);
  endtask

  // clk_ctrl bits 11..0: core sel, core run, aux run, meter sel,
  // meter run, display run, pll on, pll fixed, cfg lock, light, deep, temp
  task automatic t_reset;
    get(CTRL_RESET);
    check(clk_ctrl, 12'h6c1);
    check(energy_const_accum, 1'b1);
    @(posedge mclk);
    analog_pll_enable <= 1'b1;
    tick(2);
    check(clk_ctrl.pll_enable, 1'b1);
    @(posedge mclk);
    analog_pll_enable <= 1'b0;
  endtask

  task automatic t_quick;
    put(8'h40);
    check(clk_ctrl, 12'hef8);
    check(energy_const_accum, 1'b0);
    put(8'h30);
    check(clk_ctrl[11:3], 9'h0c8);
    tick(7);
    check(clk_ctrl.core_clk_run, 1'b1);
    tick(1);
    check({clk_ctrl[10:9], clk_ctrl[2:1]}, 4'h2);
    wake_without_reset_sel <= 1'b1;
    pulse(1'b1);
    check({clk_ctrl[10:9], clk_ctrl[2:0]}, 5'h19);
    get(8'h10);
  endtask

  task automatic t_pg;
    put(8'h40);
    power_good_flag <= 1'b1;
    tick(4);
    put(8'h20);
    check(clk_ctrl.core_clk_sel, 1'b0);
    tick(10);
    check({clk_ctrl.core_clk_run, clk_ctrl.light_sleep_state}, 2'h2);
    put(8'h40);
    check(clk_ctrl.core_clk_sel, 1'b0);
    get(8'h00);
    pulse(1'b0);
    get(8'h00);
    power_good_flag <= 1'b0;
    tick(4);
  endtask

  task automatic t_codes;
    codes = '{8'h02, 8'h04, 8'h06};
    wake_without_reset_sel <= 1'b0;
    foreach (codes[i])
    begin
      put(codes[i]);
      tick(8);
      check(clk_ctrl[2:1], codes[i] == 8'h04 ? 2'h1 : 2'h2);
      pulse(1'b1);
      get(8'h00);
    end
  endtask

  task automatic t_display;
    put(8'h08);
    check(clk_ctrl.display_clk_run, 1'b1);
    put(8'h40);
    put(8'hc8);
    check({clk_ctrl.meter_clk_sel, clk_ctrl.display_clk_run}, 2'h2);
    get(8'hc9);
    put(8'h88);
    check({clk_ctrl.core_clk_sel, clk_ctrl.pll_cfg_block}, 2'h2);
    pulse(1'b0);
    check(clk_ctrl, 12'h6c1);
  endtask

  // wake then select, deselect then sleep
  task automatic t_combined;
    put(8'h40);
    put(8'h41);
    get(8'h41);
    put(8'h00);
    get(8'h01);
    put(8'h00);
    check(clk_ctrl.core_clk_sel, 1'b0);
    put(8'h20);
    tick(8);
    check({clk_ctrl.core_clk_run, clk_ctrl.light_sleep_state}, 2'h1);
  endtask

  initial
  begin
    rst_n = 1'b0;
    sfr_req = '0;
    power_good_flag = 1'b0;
    reset_event = 1'b0;
    wake_event = 1'b0;
    wake_without_reset_sel = 1'b0;
    analog_pll_enable = 1'b0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_quick;
    t_pg;
    t_codes;
    t_display;
    t_combined;
    give_verdict;
  end
endmodule
`default_nettype wire
